// ==== wp_pkg.sv ====
package wp_pkg;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_LATCH_SET   = 8'h06;
    localparam logic [7:0] OP_WRITE_LATCH_CLR   = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE      = 8'h01;
    localparam logic [7:0] OP_FULL_ERASE_A      = 8'hC7;
    localparam logic [7:0] OP_FULL_ERASE_B      = 8'h60;
    localparam logic [7:0] OP_VOL_READ_PARAM    = 8'hC0;
    localparam logic [7:0] OP_VOL_BANK_WRITE    = 8'h17;

    // ------------------------------------------------------------
    // status bit positions and reset values
    // ------------------------------------------------------------
    localparam int         SR_BP_LSB            = 2;
    localparam int         SR_BP_MSB            = 5;
    localparam int         SR_QE_POS            = 6;
    localparam int         SR_SWD_POS           = 7;
    localparam logic [7:0] SR_WRITABLE_MASK     = 8'hFC;
    localparam logic [7:0] SR_RESET_VALUE       = 8'h00;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int         BLK64_COUNT          = 512;
    localparam int         BLK256_COUNT         = 128;
    localparam int         BLK64_ADDR_LSB       = 16;
    localparam int         BLK256_ADDR_LSB      = 18;
    localparam int         ADDR_W               = 25;
    localparam int         BLK_W                = 10;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_OTHER,
        KIND_PROGRAM,
        KIND_SECTOR_ERASE,
        KIND_FULL_ERASE
    } op_kind_t;

    typedef struct packed {
        logic [7:0]        opcode;
        op_kind_t          kind;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } cmd_t;

    typedef struct packed {
        logic       swd;
        logic       qe;
        logic [3:0] bp;
    } prot_t;

endpackage

// ==== wp_region_decode.sv ====
module wp_region_decode (
    input  wire logic [3:0]               bp,
    input  wire logic                     bottom,
    input  wire logic                     large_blocks,
    input  wire logic [wp_pkg::ADDR_W-1:0] addr,
    output logic                          hit
);
    // ------------------------------------------------------------
    // protected block count
    // ------------------------------------------------------------
    function automatic logic [wp_pkg::BLK_W-1:0] count64(input logic [3:0] c);
        case (c)
            4'h0:     count64 = 10'd0;
            4'd10:    count64 = 10'd384;
            4'd11:    count64 = 10'd448;
            4'd12:    count64 = 10'd480;
            4'd13:    count64 = 10'd496;
            4'd14:    count64 = 10'd504;
            4'd15:    count64 = 10'd512;
            default:  count64 = 10'(10'd1 << (c - 4'd1));
        endcase
    endfunction

    function automatic logic [wp_pkg::BLK_W-1:0] count256(input logic [3:0] c);
        if (c[3]) begin
            count256 = 10'd128;
        end else if (c == 4'd0) begin
            count256 = 10'd0;
        end else begin
            count256 = 10'(10'd1 << (c[2:0] - 3'd1));
        end
    endfunction

    logic [wp_pkg::BLK_W-1:0] nprot;
    logic [wp_pkg::BLK_W-1:0] total;
    logic [wp_pkg::BLK_W-1:0] blk;

    always_comb begin
        if (large_blocks) begin
            nprot = count256(bp);
            total = 10'(wp_pkg::BLK256_COUNT);
            blk   = 10'(addr[wp_pkg::ADDR_W-1:wp_pkg::BLK256_ADDR_LSB]);
        end else begin
            nprot = count64(bp);
            total = 10'(wp_pkg::BLK64_COUNT);
            blk   = 10'(addr[wp_pkg::ADDR_W-1:wp_pkg::BLK64_ADDR_LSB]);
        end
        // top region ends at the highest block, bottom starts at block zero
        if (bottom) begin
            hit = blk < nprot;
        end else begin
            hit = blk >= 10'(total - nprot);
        end
    end

endmodule

// ==== wp_pin_mux.sv ====
module wp_pin_mux (
    input  wire logic qe,
    input  wire logic line2_in,
    input  wire logic line3_in,
    input  wire logic line2_drv,
    input  wire logic line3_drv,
    input  wire logic line2_oe_req,
    input  wire logic line3_oe_req,
    output logic      line2_out,
    output logic      line3_out,
    output logic      line2_oe,
    output logic      line3_oe,
    output logic      wp_level,
    output logic      hold_n,
    output logic      data2_in,
    output logic      data3_in
);
    always_comb begin
        if (qe) begin
            // pins act as data lines
            line2_oe  = line2_oe_req;
            line3_oe  = line3_oe_req;
            wp_level  = 1'b1;
            hold_n    = 1'b1;
            data2_in  = line2_in;
            data3_in  = line3_in;
        end else begin
            // pins are inputs: write protect and hold
            line2_oe  = 1'b0;
            line3_oe  = 1'b0;
            wp_level  = line2_in;
            hold_n    = line3_in;
            data2_in  = 1'b0;
            data3_in  = 1'b0;
        end
        line2_out = line2_drv;
        line3_out = line3_drv;
    end

endmodule

// ==== flash_block_write_protect.sv ====
module flash_block_write_protect (
    input  wire logic          core_clk,
    input  wire logic          rstn,
    input  wire logic          large_blocks,
    input  wire logic          top_bottom_select,
    input  wire logic          cmd_valid,
    input  wire wp_pkg::cmd_t  cmd,
    input  wire logic          quad_data_line_2_in,
    input  wire logic          quad_data_line_3_in,
    input  wire logic          quad_data_line_2_drv,
    input  wire logic          quad_data_line_3_drv,
    input  wire logic          quad_data_line_2_oe_req,
    input  wire logic          quad_data_line_3_oe_req,
    output logic               quad_data_line_2_out,
    output logic               quad_data_line_3_out,
    output logic               quad_data_line_2_oe,
    output logic               quad_data_line_3_oe,
    output logic               hold_n,
    output logic               data2_in,
    output logic               data3_in,
    output logic [7:0]         status_r,
    output wp_pkg::prot_t      prot,
    output logic               write_latch_r,
    output logic               op_grant_r,
    output logic               op_inhibit_r,
    output logic               status_locked
);
    // ------------------------------------------------------------
    // shared pins and region decode
    // ------------------------------------------------------------
    logic wp_level;
    logic region_hit;

    assign prot.bp  = status_r[wp_pkg::SR_BP_MSB:wp_pkg::SR_BP_LSB];
    assign prot.qe  = status_r[wp_pkg::SR_QE_POS];
    assign prot.swd = status_r[wp_pkg::SR_SWD_POS];

    wp_pin_mux u_pins (
        .qe           (prot.qe),
        .line2_in     (quad_data_line_2_in),
        .line3_in     (quad_data_line_3_in),
        .line2_drv    (quad_data_line_2_drv),
        .line3_drv    (quad_data_line_3_drv),
        .line2_oe_req (quad_data_line_2_oe_req),
        .line3_oe_req (quad_data_line_3_oe_req),
        .line2_out    (quad_data_line_2_out),
        .line3_out    (quad_data_line_3_out),
        .line2_oe     (quad_data_line_2_oe),
        .line3_oe     (quad_data_line_3_oe),
        .wp_level     (wp_level),
        .hold_n       (hold_n),
        .data2_in     (data2_in),
        .data3_in     (data3_in)
    );

    wp_region_decode u_region (
        .bp           (prot.bp),
        .bottom       (top_bottom_select),
        .large_blocks (large_blocks),
        .addr         (cmd.addr),
        .hit          (region_hit)
    );

    // ------------------------------------------------------------
    // command classification
    // ------------------------------------------------------------
    logic is_latch_set;
    logic is_latch_clr;
    logic is_status_wr;
    logic is_full_erase;
    logic is_no_latch;
    logic is_array_op;
    logic status_wr_ok;
    logic array_ok;

    always_comb begin
        is_latch_set  = cmd.opcode == wp_pkg::OP_WRITE_LATCH_SET;
        is_latch_clr  = cmd.opcode == wp_pkg::OP_WRITE_LATCH_CLR;
        is_status_wr  = cmd.opcode == wp_pkg::OP_STATUS_WRITE;
        is_full_erase = cmd.kind == wp_pkg::KIND_FULL_ERASE;
        is_no_latch   = cmd.opcode == wp_pkg::OP_VOL_READ_PARAM ||
                        cmd.opcode == wp_pkg::OP_VOL_BANK_WRITE;
        is_array_op   = cmd.kind == wp_pkg::KIND_PROGRAM ||
                        cmd.kind == wp_pkg::KIND_SECTOR_ERASE;
        status_locked = prot.swd && !wp_level;
        status_wr_ok  = write_latch_r && !status_locked;
        if (is_full_erase) begin
            array_ok = write_latch_r && prot.bp == 4'h0;
        end else begin
            array_ok = write_latch_r && !region_hit;
        end
    end

    // ------------------------------------------------------------
    // write latch
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            write_latch_r <= 1'b0;
        end else if (cmd_valid) begin
            if (is_latch_set) begin
                write_latch_r <= 1'b1;
            end else if (is_latch_clr || (is_status_wr && write_latch_r) ||
                         ((is_array_op || is_full_erase) && write_latch_r)) begin
                write_latch_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            status_r <= wp_pkg::SR_RESET_VALUE;
        end else if (cmd_valid && is_status_wr && status_wr_ok) begin
            status_r <= (cmd.wdata & wp_pkg::SR_WRITABLE_MASK) |
                        (status_r & ~wp_pkg::SR_WRITABLE_MASK);
        end
    end

    // ------------------------------------------------------------
    // grant and inhibit report, one cycle per command
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            op_grant_r   <= 1'b0;
            op_inhibit_r <= 1'b0;
        end else begin
            op_grant_r   <= 1'b0;
            op_inhibit_r <= 1'b0;
            if (cmd_valid) begin
                if (is_no_latch) begin
                    op_grant_r <= 1'b1;
                end else if (is_array_op || is_full_erase) begin
                    op_grant_r   <= array_ok;
                    op_inhibit_r <= !array_ok;
                end else if (is_status_wr) begin
                    op_grant_r   <= status_wr_ok;
                    op_inhibit_r <= !status_wr_ok;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_locked_write;
        cmd_valid && is_status_wr && status_locked;
    endsequence

    a_locked_status_kept: assert property (@(posedge core_clk) disable iff (!rstn)
        s_locked_write |=> $stable(status_r) && op_inhibit_r)
        else $error("status changed while locked");

    a_unlocked_write: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_status_wr && write_latch_r && !prot.swd
        |=> status_r[7:2] == $past(cmd.wdata[7:2]))
        else $error("unlocked status write lost");

    a_pin_write: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_status_wr && write_latch_r && wp_level |=> op_grant_r)
        else $error("status write refused with protect pin high");

    a_full_erase_gate: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_full_erase && prot.bp != 4'h0 |=> op_inhibit_r && !op_grant_r)
        else $error("full erase allowed with protect bits set");

    a_region_inhibit: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_array_op && region_hit |=> !op_grant_r)
        else $error("protected region op granted");

    a_no_latch_ops: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_no_latch |=> op_grant_r)
        else $error("volatile op refused");

    a_pins_inputs: assert property (@(posedge core_clk) disable iff (!rstn)
        !prot.qe |-> !quad_data_line_2_oe && !quad_data_line_3_oe
                     && hold_n == quad_data_line_3_in)
        else $error("shared pins driven with quad off");

    a_pins_data: assert property (@(posedge core_clk) disable iff (!rstn)
        prot.qe |-> quad_data_line_2_oe == quad_data_line_2_oe_req && hold_n)
        else $error("quad pins not data lines");

    a_all_protect: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_array_op && prot.bp == 4'hF |=> !op_grant_r)
        else $error("all-protect code let op through");

    // ------------------------------------------------------------
    // latch, status, pin, array and region checks
    // ------------------------------------------------------------
    sequence s_array_req;
        cmd_valid && (is_array_op || is_full_erase);
    endsequence

    sequence s_armed_array;
        s_array_req ##0 write_latch_r;
    endsequence

    sequence s_unarmed_status;
        cmd_valid && is_status_wr && !write_latch_r;
    endsequence

    sequence s_latch_used;
        cmd_valid && write_latch_r && !is_latch_set
        && (is_status_wr || is_array_op || is_full_erase);
    endsequence

    a_reset_values: assert property (@(posedge core_clk)
        !rstn |-> status_r == wp_pkg::SR_RESET_VALUE && !write_latch_r
                  && !op_grant_r && !op_inhibit_r)
        else $error("state not cleared in reset");

    a_array_unarmed: assert property (@(posedge core_clk) disable iff (!rstn)
        s_array_req ##0 !write_latch_r |=> op_inhibit_r && !op_grant_r)
        else $error("array op granted without latch");

    a_region_grant: assert property (@(posedge core_clk) disable iff (!rstn)
        s_armed_array ##0 (is_array_op && !region_hit) |=> op_grant_r)
        else $error("free region op refused");

    a_erase_free: assert property (@(posedge core_clk) disable iff (!rstn)
        s_armed_array ##0 (is_full_erase && prot.bp == 4'h0) |=> op_grant_r)
        else $error("full erase refused with protect bits clear");

    a_status_unarmed: assert property (@(posedge core_clk) disable iff (!rstn)
        s_unarmed_status |=> $stable(status_r) && op_inhibit_r)
        else $error("status written without latch");

    a_latch_set: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_latch_set |=> write_latch_r)
        else $error("latch not set");

    a_latch_used: assert property (@(posedge core_clk) disable iff (!rstn)
        s_latch_used |=> !write_latch_r)
        else $error("latch kept after use");

    a_latch_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_latch_clr |=> !write_latch_r)
        else $error("latch not cleared");

    a_status_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
        !(cmd_valid && is_status_wr) |=> $stable(status_r))
        else $error("status changed without a status write");

    a_low_bits_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        status_r[1:0] == 2'h0)
        else $error("status low bits set");

    a_lock_flag: assert property (@(posedge core_clk) disable iff (!rstn)
        prot.swd && !prot.qe && !quad_data_line_2_in |-> status_locked)
        else $error("lock flag missing");

    a_free_flag: assert property (@(posedge core_clk) disable iff (!rstn)
        !prot.swd |-> !status_locked)
        else $error("lock flag with write-disable clear");

    a_no_latch_free: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_no_latch |=> !op_inhibit_r)
        else $error("volatile op inhibited");

    a_out_pass: assert property (@(posedge core_clk) disable iff (!rstn)
        quad_data_line_2_out == quad_data_line_2_drv
        && quad_data_line_3_out == quad_data_line_3_drv)
        else $error("pin output not the core data");

    a_quad_inputs: assert property (@(posedge core_clk) disable iff (!rstn)
        prot.qe |-> data2_in == quad_data_line_2_in && data3_in == quad_data_line_3_in
                    && quad_data_line_3_oe == quad_data_line_3_oe_req)
        else $error("quad line three not a data line");

    a_plain_data: assert property (@(posedge core_clk) disable iff (!rstn)
        !prot.qe |-> !data2_in && !data3_in)
        else $error("data inputs live with quad off");

    a_top_end_block: assert property (@(posedge core_clk) disable iff (!rstn)
        s_armed_array ##0 (is_array_op && !top_bottom_select && prot.bp != 4'h0
        && cmd.addr[wp_pkg::ADDR_W-1:wp_pkg::BLK64_ADDR_LSB] == 9'h1FF) |=> !op_grant_r)
        else $error("highest block open with top protection");

    a_bottom_first: assert property (@(posedge core_clk) disable iff (!rstn)
        s_armed_array ##0 (is_array_op && top_bottom_select && prot.bp != 4'h0
        && cmd.addr[wp_pkg::ADDR_W-1:wp_pkg::BLK64_ADDR_LSB] == 9'h000) |=> !op_grant_r)
        else $error("block zero open with bottom protection");

    a_large_all: assert property (@(posedge core_clk) disable iff (!rstn)
        cmd_valid && is_array_op && large_blocks && prot.bp[3] |=> !op_grant_r)
        else $error("large-block top code let op through");

    a_small_half: assert property (@(posedge core_clk) disable iff (!rstn)
        s_armed_array ##0 (is_array_op && !large_blocks && prot.bp == 4'h9
        && cmd.addr[wp_pkg::ADDR_W-1] == top_bottom_select) |=> op_grant_r)
        else $error("unprotected half refused");

endmodule

// ==== host_model.sv ====
module host_model (
    input  wire logic    core_clk,
    output logic         cmd_valid,
    output wp_pkg::cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
    end

    // ------------------------------------------------------------
    // command issue
    // ------------------------------------------------------------
    // one-cycle pulse; payload scrambled once released
    task automatic send(input logic [7:0] op, input wp_pkg::op_kind_t kind,
                        input logic [24:0] addr, input logic [7:0] wdata);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd       = '{op, kind, addr, wdata};
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd       = wp_pkg::cmd_t'(~cmd);
    endtask

    task automatic write_status(input logic [7:0] value);
        send(wp_pkg::OP_WRITE_LATCH_SET, wp_pkg::KIND_OTHER, '0, '0);
        send(wp_pkg::OP_STATUS_WRITE, wp_pkg::KIND_OTHER, '0, value);
    endtask
endmodule

// ==== flash_block_write_protect_tb_top.sv ====
module flash_block_write_protect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic          core_clk, rstn, large_blocks, top_bottom_select, cmd_valid;
    wp_pkg::cmd_t  cmd;
    logic          ext2, ext3, drv2, drv3, req2, req3, in2, in3;
    logic          out2, out3, oe2, oe3, hold_n, data2_in, data3_in, status_locked;
    logic [7:0]    status_r;
    wp_pkg::prot_t prot;
    logic          write_latch_r, op_grant_r, op_inhibit_r;
    int            num_errors = 0;
    int            tests_run = 0;

    // pins carry the DUT output while its enable is set, otherwise the bench drive
    assign in2 = oe2 ? out2 : ext2;
    assign in3 = oe3 ? out3 : ext3;

    host_model i_host_model (.core_clk, .cmd_valid, .cmd);

    flash_block_write_protect i_flash_block_write_protect (
        .core_clk, .rstn, .large_blocks, .top_bottom_select, .cmd_valid, .cmd,
        .quad_data_line_2_in(in2), .quad_data_line_3_in(in3),
        .quad_data_line_2_drv(drv2), .quad_data_line_3_drv(drv3),
        .quad_data_line_2_oe_req(req2), .quad_data_line_3_oe_req(req3),
        .quad_data_line_2_out(out2), .quad_data_line_3_out(out3),
        .quad_data_line_2_oe(oe2), .quad_data_line_3_oe(oe3),
        .hold_n, .data2_in, .data3_in, .status_r, .prot, .write_latch_r,
        .op_grant_r, .op_inhibit_r, .status_locked
    );

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic int prot_blocks(int code, logic lb);
        int tail[5] = '{384, 448, 480, 496, 504};
        if (code == 0) return 0;
        if (lb) return (code >= 8) ? 128 : (1 << (code - 1));
        if (code <= 9) return 1 << (code - 1);
        return (code == 15) ? 512 : tail[code - 10];
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        check(status_r, 8'h00, "status reset");
        check({write_latch_r, op_grant_r, op_inhibit_r}, 8'h00, "latch reset");
        i_host_model.write_status(8'h7C);
        i_host_model.send(wp_pkg::OP_WRITE_LATCH_SET, wp_pkg::KIND_OTHER, '0, '0);
        check({write_latch_r, status_r[6:0]}, 8'hFC, "before reset");
        @(negedge core_clk) rstn = 1'b0;
        #1 check({write_latch_r, status_r[6:0]}, 8'h00, "mid-run reset");
        @(negedge core_clk) rstn = 1'b1;
    endtask

    task automatic test_latch_free();
        i_host_model.send(8'hC0, wp_pkg::KIND_OTHER, '0, '0);
        check({op_grant_r, op_inhibit_r}, 8'h02, "read param grant");
        i_host_model.send(8'h17, wp_pkg::KIND_OTHER, '0, '0);
        check({op_grant_r, op_inhibit_r}, 8'h02, "bank write grant");
        i_host_model.send(wp_pkg::OP_STATUS_WRITE, wp_pkg::KIND_OTHER, '0, 8'h3C);
        check({op_grant_r, op_inhibit_r}, 8'h01, "no latch refuse");
        check(status_r, 8'h00, "no latch keep");
        i_host_model.send(wp_pkg::OP_WRITE_LATCH_SET, wp_pkg::KIND_OTHER, '0, '0);
        check(write_latch_r, 8'h01, "latch set");
        i_host_model.send(wp_pkg::OP_WRITE_LATCH_CLR, wp_pkg::KIND_OTHER, '0, '0);
        check(write_latch_r, 8'h00, "latch clear");
    endtask

    task automatic test_status_lock();
        i_host_model.write_status(8'h80);
        check(status_r, 8'h80, "swd set");
        @(negedge core_clk) ext2 = 1'b0;
        #1 check(status_locked, 8'h01, "locked");
        i_host_model.write_status(8'h00);
        check({op_grant_r, op_inhibit_r}, 8'h01, "locked refuse");
        check(status_r, 8'h80, "locked keep");
        @(negedge core_clk) ext2 = 1'b1;
        i_host_model.write_status(8'h00);
        check(status_r, 8'h00, "pin high write");
        @(negedge core_clk) ext2 = 1'b0;
        i_host_model.write_status(8'h3F);
        check(status_r, 8'h3C, "swd clear write");
        i_host_model.write_status(8'h00);
        @(negedge core_clk) ext2 = 1'b1;
    endtask

    task automatic test_full_erase();
        logic [7:0] ops[2];
        ops = '{wp_pkg::OP_FULL_ERASE_A, wp_pkg::OP_FULL_ERASE_B};
        foreach (ops[k]) begin
            i_host_model.write_status(8'h00);
            i_host_model.send(wp_pkg::OP_WRITE_LATCH_SET, wp_pkg::KIND_OTHER, '0, '0);
            i_host_model.send(ops[k], wp_pkg::KIND_FULL_ERASE, '0, '0);
            check({op_grant_r, op_inhibit_r}, 8'h02, "erase free");
            i_host_model.write_status(8'h20);
            i_host_model.send(wp_pkg::OP_WRITE_LATCH_SET, wp_pkg::KIND_OTHER, '0, '0);
            i_host_model.send(ops[k], wp_pkg::KIND_FULL_ERASE, '0, '0);
            check({op_grant_r, op_inhibit_r}, 8'h01, "erase blocked");
        end
    endtask

    task automatic test_quad();
        logic [7:0] exp;
        for (int q = 1; q >= 0; q--) begin
            i_host_model.write_status(8'(q << 6));
            check(prot.qe, 8'(q), "qe bit");
            for (int v = 0; v < 64; v++) begin
                @(negedge core_clk);
                {drv2, req2, drv3, req3, ext2, ext3} = 6'(v);
                #1 exp = q ? {1'b0, drv2, drv3, req2, req3, req2 ? drv2 : ext2,
                              req3 ? drv3 : ext3, 1'b1} : {1'b0, drv2, drv3, 4'h0, ext3};
                check({1'b0, out2, out3, oe2, oe3, data2_in, data3_in, hold_n}, exp, "pins");
            end
        end
        @(negedge core_clk);
        {drv2, req2, drv3, req3, ext2, ext3} = 6'b000011;
    endtask

    task automatic test_regions();
        int n, total, blk, probe[4];
        logic hit;
        logic [24:0] addr;
        for (int lb = 0; lb < 2; lb++) begin
            for (int bot = 0; bot < 2; bot++) begin
                @(negedge core_clk);
                large_blocks      = lb[0];
                top_bottom_select = bot[0];
                for (int code = 0; code < 16; code++) begin
                    i_host_model.write_status(8'(code << 2));
                    n     = prot_blocks(code, lb[0]);
                    total = lb ? 128 : 512;
                    probe = '{n - 1, n, total - n - 1, total - n};
                    foreach (probe[k]) begin
                        blk  = probe[k] < 0 ? 0 : (probe[k] >= total ? total - 1 : probe[k]);
                        hit  = bot ? (blk < n) : (blk >= total - n);
                        addr = (lb ? 25'(blk) << 18 : 25'(blk) << 16) + 25'h0123;
                        i_host_model.send(wp_pkg::OP_WRITE_LATCH_SET,
                                          wp_pkg::KIND_OTHER, '0, '0);
                        i_host_model.send(8'h02, k[0] ? wp_pkg::KIND_SECTOR_ERASE
                                          : wp_pkg::KIND_PROGRAM, addr, '0);
                        check({op_grant_r, op_inhibit_r}, {6'h0, !hit, hit}, "region");
                    end
                end
            end
        end
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        {large_blocks, top_bottom_select, drv2, drv3, req2, req3} = '0;
        {ext2, ext3} = 2'b11;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk) rstn = 1'b1;
        test_reset();
        test_latch_free();
        test_status_lock();
        test_full_erase();
        test_quad();
        test_regions();
        give_verdict();
    end

    initial begin
        #100_000;
        num_errors++;
        give_verdict();
    end
endmodule
